/* src/stabilization_watchdog_timer.sv */
// Stabilization and watchdog timer: prescaler, 8-bit counter, control register.
// Assumes the CPU register port is synchronous to clock_i and that stop mode
// requests and wake events are single-cycle pulses from logic on the same clock.
`timescale 1ns/1ps

// Function
// - Watchdog disabled only by key 1010b.
// - Two-bit field picks divide 4096/1024/128/16.
// - Writing 1 to bit1 clears counter.
// - Writing 1 to bit0 clears dividers.
// - Reset loads control register with zero.
// - Enabled watchdog resets chip on overflow.
// - Overflow is bit7 carry; count read-only.
// - After reset counter clock is system/4096.
// - Leaving stop: count at reset or preset rate.
// - Bit4 overflow ends stabilization, releases CPU.
module stabilization_watchdog_timer
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// CPU register port
	input wire stabilization_watchdog_timer_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	// Power management
	input wire logic stop_enter_i,
	input wire logic ext_wake_i,
	// System side
	output logic counter_overflow_signal_o,
	output logic watchdog_reset_o,
	output logic cpu_clock_enable_o,
	output logic divider_clear_o
);
	import stabilization_watchdog_timer_pkg::*;

	logic [7:0] timer_control_ff;
	logic [divider_width-1:0] divider_ff;
	logic [divider_width-1:0] nxt_divider;
	logic [7:0] count_ff;
	logic [8:0] nxt_count_sum;
	run_state_t state_ff;
	logic tick_ff;
	logic tick_prev_bit;
	logic tick_now;
	logic ctl_wr;
	logic cnt_clear_pulse;
	logic div_clear_pulse;
	logic wdt_enabled;
	logic [7:0] rdata_ff;
	logic ovf_ff;
	logic wdt_rst_ff;
	logic cpu_en_ff;
	logic div_clr_ff;
	logic ctl_rd;
	logic cnt_rd;
	logic count_carry;
	logic stab_done;
	logic wake_now;

	// ==========================================================================
	// Register decode
	// One compare serves reads and writes, so both see the same map.
	function automatic logic reg_hit(input reg_req_t r, input logic [7:0] target);
		reg_hit = (r.addr == target);
	endfunction

	assign ctl_wr = req_i.wr && reg_hit(req_i, timer_control_addr);
	assign ctl_rd = req_i.rd && reg_hit(req_i, timer_control_addr);
	assign cnt_rd = req_i.rd && reg_hit(req_i, timer_count_value_addr);
	// Clear bits are decoded straight from the write, never stored as levels.
	assign cnt_clear_pulse = ctl_wr && req_i.wdata[cnt_clear_bit];
	assign div_clear_pulse = ctl_wr && req_i.wdata[div_clear_bit];
	assign wdt_enabled = (timer_control_ff[wdt_key_msb:wdt_key_lsb] != wdt_disable_key);

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			timer_control_ff <= timer_control_reset;
		else if (ctl_wr)
			timer_control_ff <= {req_i.wdata[7:2], 2'h0};
	end

	// ==========================================================================
	// Read-back
	// The count register has no write path, so a store to it is ignored.
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			rdata_ff <= 8'h00;
		else if (ctl_rd)
			rdata_ff <= timer_control_ff;
		else if (cnt_rd)
			rdata_ff <= count_ff;
		else
			rdata_ff <= 8'h00;
	end

	// ==========================================================================
	// Prescaler
	assign nxt_divider = divider_ff + 12'h001;

	// A tick is the falling edge of the selected divider bit, one cycle wide.
	function automatic logic tap(input logic [divider_width-1:0] d, input logic [1:0] sel);
		unique case (sel)
			sel_div4096: tap = d[11];
			sel_div1024: tap = d[9];
			sel_div128: tap = d[6];
			sel_div16: tap = d[3];
		endcase
	endfunction

	always_ff @(posedge clock_i)
	begin
		if (reset_i || div_clear_pulse)
			divider_ff <= '0;
		else
			divider_ff <= nxt_divider;
	end

	assign tick_prev_bit = tap(divider_ff, timer_control_ff[clk_sel_msb:clk_sel_lsb]);
	assign tick_now = tick_prev_bit && !tap(nxt_divider, timer_control_ff[clk_sel_msb:clk_sel_lsb]);

	always_ff @(posedge clock_i)
	begin
		if (reset_i || div_clear_pulse)
			tick_ff <= 1'b0;
		else
			tick_ff <= tick_now;
	end

	// ==========================================================================
	// Stop mode sequencing
	// Bit 4 carries when the low five bits roll over.
	assign stab_done = tick_ff && (&count_ff[stab_bit:0]);
	assign wake_now = (state_ff == st_stop) && ext_wake_i;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			state_ff <= st_stabilize;
		else
			unique case (state_ff)
				st_stabilize:
				begin
					if (stab_done)
						state_ff <= st_run;
				end
				st_run:
				begin
					if (stop_enter_i)
						state_ff <= st_stop;
				end
				st_stop:
				begin
					// Wake keeps the preset prescaler; only a reset forces /4096.
					if (ext_wake_i)
						state_ff <= st_stabilize;
				end
			endcase
	end

	// ==========================================================================
	// Counter
	assign nxt_count_sum = {1'b0, count_ff} + 9'h001;
	// A clear in the same cycle beats the carry, so no overflow is seen.
	assign count_carry = tick_ff && nxt_count_sum[8] && !cnt_clear_pulse;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			count_ff <= 8'h00;
		else if (cnt_clear_pulse || wake_now)
			count_ff <= 8'h00;
		else if (tick_ff && state_ff != st_stop)
			count_ff <= nxt_count_sum[7:0];
	end

	// ==========================================================================
	// Overflow and watchdog outputs
	// Overflow is gated off by state in stop mode, so no carry can be reported there.
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			ovf_ff <= 1'b0;
		else
			ovf_ff <= count_carry && state_ff != st_stop;
	end

	// During stabilization the watchdog cannot fire: bit 4 ends it first.
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			wdt_rst_ff <= 1'b0;
		else
			wdt_rst_ff <= wdt_enabled && count_carry && state_ff == st_run;
	end

	// ==========================================================================
	// CPU clock and divider clear outputs
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			cpu_en_ff <= 1'b0;
		else
			cpu_en_ff <= (state_ff == st_run) && !stop_enter_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			div_clr_ff <= 1'b0;
		else
			div_clr_ff <= div_clear_pulse;
	end

	assign rdata_o = rdata_ff;
	assign counter_overflow_signal_o = ovf_ff;
	assign watchdog_reset_o = wdt_rst_ff;
	assign cpu_clock_enable_o = cpu_en_ff;
	assign divider_clear_o = div_clr_ff;

endmodule

/* src/stabilization_watchdog_timer_pkg.sv */
// Constants and carrier types for the stabilization and watchdog timer.
// Assumes one 125 MHz system clock and a byte-wide register port from the CPU core.
package stabilization_watchdog_timer_pkg;

	// ==========================================================================
	// Register map
	localparam logic [7:0] timer_control_addr = 8'hd3;
	localparam logic [7:0] timer_count_value_addr = 8'hfd;
	localparam logic [7:0] timer_control_reset = 8'h00;

	// ==========================================================================
	// Control field layout
	localparam int wdt_key_msb = 7;
	localparam int wdt_key_lsb = 4;
	localparam logic [3:0] wdt_disable_key = 4'ha;
	localparam int clk_sel_msb = 3;
	localparam int clk_sel_lsb = 2;
	localparam int cnt_clear_bit = 1;
	localparam int div_clear_bit = 0;

	// ==========================================================================
	// Prescaler
	localparam int divider_width = 12;
	localparam logic [1:0] sel_div4096 = 2'h0;
	localparam logic [1:0] sel_div1024 = 2'h1;
	localparam logic [1:0] sel_div128 = 2'h2;
	localparam logic [1:0] sel_div16 = 2'h3;
	localparam int stab_bit = 4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		st_stabilize,
		st_run,
		st_stop
	} run_state_t;

endpackage

/* tb/swt_asserts.sv */
// Port checker for the timer.
// Assumes a bind to the design top module.
`timescale 1ns/1ps
// ====
// Checks
module swt_asserts
(
	// Clock, reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Inputs
	input wire stabilization_watchdog_timer_pkg::reg_req_t req_i,
	input wire logic stop_enter_i,
	// Outputs
	input wire logic [7:0] rdata_o,
	input wire logic counter_overflow_signal_o,
	input wire logic watchdog_reset_o,
	input wire logic cpu_clock_enable_o,
	input wire logic divider_clear_o
);
	wire ovf = counter_overflow_signal_o;
	wire wr_ctl = req_i.wr && req_i.addr == 8'hd3;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	chk_wdog_ovf: assert property (watchdog_reset_o |-> ovf)
		else $error("reset without overflow");
	chk_ovf_one: assert property (ovf |=> !ovf)
		else $error("long overflow pulse");
	chk_dclr_one: assert property (
		divider_clear_o && !(wr_ctl && req_i.wdata[0]) |=> !divider_clear_o)
		else $error("long divider clear");
	chk_dclr_cause: assert property (divider_clear_o |-> $past(wr_ctl && req_i.wdata[0]))
		else $error("divider clear uncaused");
	chk_rd_idle: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	chk_strobe_rd: assert property (
		$past(req_i.rd && req_i.addr == 8'hd3) |-> rdata_o[1:0] == 2'h0)
		else $error("strobe bits read back");
	chk_stop_cpu: assert property (
		stop_enter_i && cpu_clock_enable_o |=> !cpu_clock_enable_o)
		else $error("cpu clock kept in stop");
	chk_clr_ovf: assert property (wr_ctl && req_i.wdata[1] |=> ##1 !ovf [*4])
		else $error("overflow after clear");
endmodule
bind stabilization_watchdog_timer swt_asserts swt_asserts_inst (.clock_i, .reset_i, .req_i,
	.stop_enter_i, .rdata_o, .counter_overflow_signal_o, .watchdog_reset_o,
	.cpu_clock_enable_o, .divider_clear_o);

/* tb/sys_reset_model.sv */
// System reset model: power-on reset merged with watchdog requests.
// Assumes a one-cycle watchdog pulse on the same clock.
`timescale 1ns/1ps
// ====
// Reset stretcher
module sys_reset_model
(
	// Clock, requests
	input wire logic clock_i,
	input wire logic por_i,
	input wire logic wdog_i,
	// Chip reset
	output logic reset_o
);
	logic [2:0] hold_ff;
	// Stretched so that a one-cycle reset cannot hide slow clearing.
	always_ff @(posedge clock_i)
	begin
		if (por_i || wdog_i)
			hold_ff <= 3'h5;
		else if (hold_ff != 3'h0)
			hold_ff <= hold_ff - 3'h1;
	end
	assign reset_o = por_i || hold_ff != 3'h0;
endmodule

/* tb/tb.sv */
// Bench for the timer with the reset model.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t %h %h", $time, (a), (b)); end end
// ====
// Bench
module tb;
	import stabilization_watchdog_timer_pkg::*;
	logic clock_i = 0;
	logic por = 1;
	logic reset_i;
	reg_req_t req_i = '0;
	logic stop_enter_i = 0;
	logic ext_wake_i = 0;
	logic [7:0] rdata_o;
	logic [7:0] v;
	logic [3:0] k;
	logic ovf;
	logic wd;
	logic cen;
	logic dclr;
	int errors = 0;
	int samples_checked = 0;
	int n;
	logic [31:0] rnd = 32'h957c;
	always #4 clock_i = ~clock_i;
	sys_reset_model sys_reset_model_inst (.clock_i, .por_i(por), .wdog_i(wd), .reset_o(reset_i));
	stabilization_watchdog_timer stabilization_watchdog_timer_inst (.clock_i, .reset_i, .req_i,
		.rdata_o, .stop_enter_i, .ext_wake_i, .counter_overflow_signal_o(ovf),
		.watchdog_reset_o(wd), .cpu_clock_enable_o(cen), .divider_clear_o(dclr));
	function logic [31:0] nxt(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function int div_of(int s);
		return s == 0 ? 4096 : s == 1 ? 1024 : s == 2 ? 128 : 16;
	endfunction
	task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clock_i);
		req_i <= '{w, !w, a, d};
		@(posedge clock_i);
		req_i <= '0;
		#1 v = rdata_o;
	endtask
	task automatic upto(int lim, ref logic s);
		n = 0;
		while (!s && n < lim)
		begin
			@(posedge clock_i);
			#1 n++;
		end
	endtask
	task automatic stab;
		upto(600, cen);
		`CHK(n inside {[496:520]}, 1'b1)
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#480000;
		errors++;
		stop_test;
	end
	initial
	begin
		repeat (6) @(posedge clock_i);
		por <= 0;
		while (reset_i) @(posedge clock_i);
		acc(0, 8'hd3, 0);
		`CHK(v, 8'h00)
		acc(1, 8'hd3, 8'h0f);
		`CHK(dclr, 1'b1)
		stab;
		for (int s = 0; s < 4; s++)
		begin
			acc(1, 8'hd3, {4'ha, 2'(s), 2'h3});
			repeat (div_of(s) * 7 / 2) @(posedge clock_i);
			acc(0, 8'hfd, 0);
			`CHK(v, 8'h03)
		end
		repeat (4)
		begin
			rnd = nxt(rnd);
			acc(0, {rnd[7:2], 2'h0}, 0);
			`CHK(v, 8'h00)
		end
		acc(1, 8'hfd, 8'hff);
		`CHK(dclr, 1'b0)
		acc(0, 8'hfd, 0);
		`CHK(v < 8'h10, 1'b1)
		@(posedge clock_i);
		stop_enter_i <= 1;
		@(posedge clock_i);
		stop_enter_i <= 0;
		#1 `CHK(cen, 1'b0)
		@(posedge clock_i);
		ext_wake_i <= 1;
		@(posedge clock_i);
		ext_wake_i <= 0;
		stab;
		for (int i = 0; i < 3; i++)
		begin
			rnd = nxt(rnd);
			k = i == 0 ? 4'ha : rnd[3:0];
			acc(1, 8'hd3, {k, 4'hf});
			upto(4200, ovf);
			`CHK(n, 256 * div_of(3) + 1)
			`CHK(wd, k != 4'ha)
			repeat (8) @(posedge clock_i);
			acc(0, 8'hd3, 0);
			`CHK(v, k == 4'ha ? 8'hac : 8'h00)
		end
		stop_test;
	end
endmodule
